/* File: core/kwu_pkg.sv */
// kwu_pkg: register map, field layout and reset values of the key wake-up
// unit; assumes 32-bit AHB-Lite data with one register per aligned word.
package kwu_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PINEN  = 8'h04;
  localparam logic [7:0] OFS_PVAL   = 8'h08;
  localparam logic [7:0] OFS_PDIR   = 8'h0c;
  localparam logic [7:0] OFS_PPULL  = 8'h10;
  localparam logic [7:0] OFS_PIN    = 8'h14;
  localparam logic [7:0] OFS_ISTAT  = 8'h18;
  localparam logic [7:0] OFS_ICLR   = 8'h1c;
  localparam logic [7:0] OFS_IEN    = 8'h20;
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int POS_LVL  = 0;
  localparam int POS_IE   = 1;
  localparam int POS_ACK  = 2;
  localparam int POS_FLAG = 3;
  localparam int POS_POL  = 4;
  localparam int POL_W    = 4;
  localparam int PORT_W   = 8;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  typedef struct packed {
    logic [POL_W-1:0] pol;
    logic             ie;
    logic             lvl;
  } kwu_ctrl_t;
  localparam kwu_ctrl_t CTRL_RST = '{pol: 4'h0, ie: 1'b0, lvl: 1'b0};
endpackage

/* File: core/kwu_top.sv */
// kwu_top: key wake-up unit sharing an 8-bit port, with AHB-Lite slave.
// assumes hclk is the bus clock, pin inputs are asynchronous to it and
// stop_mode / wait_mode come from clocked power control logic.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - One key unit whose eight inputs share the pins of an 8-bit port.
// - Eight enable bits let any mix of port pins act as key inputs.
// - Enabled key pins are forced to inputs, others follow port settings.
// - Software picks edge-only or edge-and-level detection.
// - Bits 3 to 0 always detect falling edges or low levels.
// - Bits 7 to 4 each pick rising/high or falling/low polarity.
// - Eight pull enable bits switch on a pull device on each input pin.
// - A key pin among bits 7 to 4 set for rising polarity gets a pulldown.
// - An enabled key event wakes the processor from wait and standby stop.
// - All eight inputs share one event flag and one interrupt enable.
// - An edge is seen as deasserted in one cycle and asserted in the next.
// - Writing one to the acknowledge bit clears the flag; it reads zero.
// - In level mode the flag stays set while any enabled input is asserted.
// - With the enable set the flag raises an interrupt, else it is polled.
module kwu_top #(
  parameter int PORT_W = kwu_pkg::PORT_W
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic [PORT_W-1:0] pin_in,
  output logic      [PORT_W-1:0] pin_out,
  output logic      [PORT_W-1:0] pin_oe,
  output logic      [PORT_W-1:0] pull_en,
  output logic      [PORT_W-1:0] pull_down,
  input  wire logic              wait_mode,
  input  wire logic              stop_mode,
  output logic                   irq,
  output logic                   wake_req
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  kwu_pkg::kwu_ctrl_t ctrl_q;
  logic [PORT_W-1:0] key_pin_enable_reg_q;
  logic [PORT_W-1:0] shared_port_value_q;
  logic [PORT_W-1:0] shared_port_direction_q;
  logic [PORT_W-1:0] shared_port_pull_enable_q;
  logic              key_event_flag_q;
  logic              key_event_flag_d;
  logic [PORT_W-1:0] sync1_q;
  logic [PORT_W-1:0] sync2_q;
  logic [PORT_W-1:0] act_prev_q;
  logic              wr_pend_q;
  logic              rd_pend_q;
  logic [7:0]        addr_q;
  logic [31:0]       hrdata_q;
  logic              hready_q;
  logic              irq_q;
  logic              wake_q;
  logic [PORT_W-1:0] pin_out_q;
  logic [PORT_W-1:0] pin_oe_q;
  logic [PORT_W-1:0] pull_en_q;
  logic [PORT_W-1:0] pull_down_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire         acc_ok   = hsel & hready & (htrans == kwu_pkg::HTRANS_NONSEQ);
  wire         wr_start = acc_ok & hwrite;
  wire         rd_start = acc_ok & ~hwrite;
  wire         wr_ctrl  = wr_pend_q & (addr_q == kwu_pkg::OFS_CTRL);
  wire         wr_pinen = wr_pend_q & (addr_q == kwu_pkg::OFS_PINEN);
  wire         wr_pval  = wr_pend_q & (addr_q == kwu_pkg::OFS_PVAL);
  wire         wr_pdir  = wr_pend_q & (addr_q == kwu_pkg::OFS_PDIR);
  wire         wr_ppull = wr_pend_q & (addr_q == kwu_pkg::OFS_PPULL);
  wire         wr_iclr  = wr_pend_q & (addr_q == kwu_pkg::OFS_ICLR);
  wire         wr_ien   = wr_pend_q & (addr_q == kwu_pkg::OFS_IEN);
  wire         ack_wr   = (wr_ctrl & hwdata[kwu_pkg::POS_ACK]) |
                          (wr_iclr & hwdata[0]);
  wire [7:0]   wbyte    = hwdata[7:0];
  wire [7:0]   ctrl_rd  = {ctrl_q.pol, key_event_flag_q, 1'b0,
                           ctrl_q.ie, ctrl_q.lvl};
  // unmapped offsets read zero and ignore writes, still OKAY
  wire [31:0]  rd_mux   =
    (addr_q == kwu_pkg::OFS_CTRL)  ? {24'h000000, ctrl_rd} :
    (addr_q == kwu_pkg::OFS_PINEN) ? {24'h000000, key_pin_enable_reg_q} :
    (addr_q == kwu_pkg::OFS_PVAL)  ? {24'h000000, shared_port_value_q} :
    (addr_q == kwu_pkg::OFS_PDIR)  ? {24'h000000, shared_port_direction_q} :
    (addr_q == kwu_pkg::OFS_PPULL) ? {24'h000000, shared_port_pull_enable_q} :
    (addr_q == kwu_pkg::OFS_PIN)   ? {24'h000000, sync2_q} :
    (addr_q == kwu_pkg::OFS_ISTAT) ? {31'h00000000, key_event_flag_q} :
    (addr_q == kwu_pkg::OFS_IEN)   ? {31'h00000000, ctrl_q.ie} :
                                     kwu_pkg::RD_ZERO;

  // ----------------------------------------------------------------
  // bus phase tracking
  // ----------------------------------------------------------------
  // reads take one wait state so they see a write that just finished
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= kwu_pkg::RST_BYTE;
      hrdata_q  <= kwu_pkg::RD_ZERO;
      hready_q  <= 1'b1;
    end else begin
      wr_pend_q <= wr_start;
      rd_pend_q <= rd_start;
      if (acc_ok) begin
        addr_q <= haddr[7:0];
      end
      if (rd_pend_q) begin
        hrdata_q <= rd_mux;
      end
      hready_q <= ~rd_start;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q                    <= kwu_pkg::CTRL_RST;
      key_pin_enable_reg_q      <= kwu_pkg::RST_BYTE;
      shared_port_value_q       <= kwu_pkg::RST_BYTE;
      shared_port_direction_q   <= kwu_pkg::RST_BYTE;
      shared_port_pull_enable_q <= kwu_pkg::RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.pol <= wbyte[kwu_pkg::POS_POL +: kwu_pkg::POL_W];
        ctrl_q.ie  <= wbyte[kwu_pkg::POS_IE];
        ctrl_q.lvl <= wbyte[kwu_pkg::POS_LVL];
      end
      if (wr_ien) begin
        ctrl_q.ie <= wbyte[0];
      end
      if (wr_pinen) begin
        key_pin_enable_reg_q <= wbyte;
      end
      if (wr_pval) begin
        shared_port_value_q <= wbyte;
      end
      if (wr_pdir) begin
        shared_port_direction_q <= wbyte;
      end
      if (wr_ppull) begin
        shared_port_pull_enable_q <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin synchroniser and detection
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= kwu_pkg::RST_BYTE;
      sync2_q <= kwu_pkg::RST_BYTE;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  wire  [PORT_W-1:0] pol_bit;
  wire  [PORT_W-1:0] active;
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi = gi + 1) begin : g_pin
      // low nibble fixed falling/low; high nibble selectable
      if (gi < kwu_pkg::POS_POL) begin : g_fix
        assign pol_bit[gi] = 1'b0;
      end else begin : g_sel
        assign pol_bit[gi] = ctrl_q.pol[gi-kwu_pkg::POS_POL];
      end
      assign active[gi] = key_pin_enable_reg_q[gi] &
                          ~(sync2_q[gi] ^ pol_bit[gi]);
    end
  endgenerate

  // deasserted then asserted on consecutive cycles
  wire edge_hit  = |(active & ~act_prev_q);
  // level mode keeps setting; stop bypasses the edge path
  wire level_hit = |active & (ctrl_q.lvl | stop_mode);
  wire set_ev    = edge_hit | level_hit;

  // one common flag; set wins over acknowledge
  always_comb begin
    key_event_flag_d = key_event_flag_q;
    if (ack_wr) begin
      key_event_flag_d = 1'b0;
    end
    if (set_ev) begin
      key_event_flag_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_prev_q       <= kwu_pkg::RST_BYTE;
      key_event_flag_q <= 1'b0;
    end else begin
      act_prev_q       <= active;
      key_event_flag_q <= key_event_flag_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q       <= 1'b0;
      wake_q      <= 1'b0;
      pin_out_q   <= kwu_pkg::RST_BYTE;
      pin_oe_q    <= kwu_pkg::RST_BYTE;
      pull_en_q   <= kwu_pkg::RST_BYTE;
      pull_down_q <= kwu_pkg::RST_BYTE;
    end else begin
      irq_q       <= key_event_flag_d & ctrl_q.ie;
      // wake from wait or stop on an enabled event
      wake_q      <= key_event_flag_d & ctrl_q.ie & (wait_mode | stop_mode);
      pin_out_q   <= shared_port_value_q;
      pin_oe_q    <= shared_port_direction_q & ~key_pin_enable_reg_q;
      // pull only on pins acting as inputs
      pull_en_q   <= shared_port_pull_enable_q &
                     (key_pin_enable_reg_q | ~shared_port_direction_q);
      // rising key pins get a pulldown
      pull_down_q <= key_pin_enable_reg_q & pol_bit;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp     = 1'b0;
  assign irq       = irq_q;
  assign wake_req  = wake_q;
  assign pin_out   = pin_out_q;
  assign pin_oe    = pin_oe_q;
  assign pull_en   = pull_en_q;
  assign pull_down = pull_down_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_key_forced_in: assert property (
    ##1 (pin_oe & $past(key_pin_enable_reg_q)) == '0)
    else $error("key pin driven as output");
  a_edge_sets_flag: assert property (
    edge_hit |=> key_event_flag_q)
    else $error("edge did not set flag");
  a_low_nibble_pol: assert property (
    active[3:0] == (key_pin_enable_reg_q[3:0] & ~sync2_q[3:0]))
    else $error("low nibble polarity not fixed");
  a_ack_clears_flag: assert property (
    (ack_wr && !set_ev && key_event_flag_q) |=> !key_event_flag_q)
    else $error("ack did not clear flag");
  a_ack_reads_zero: assert property (
    (rd_pend_q && addr_q == kwu_pkg::OFS_CTRL) |=> !hrdata[2])
    else $error("ack bit read back nonzero");
  a_level_holds: assert property (
    (ctrl_q.lvl && (|active)) [*2] |-> key_event_flag_q)
    else $error("flag cleared while level asserted");
  a_irq_follows: assert property (
    irq == $past(key_event_flag_d & ctrl_q.ie))
    else $error("irq mismatch with flag and enable");
  a_irq_masked: assert property (
    (!ctrl_q.ie && $stable(ctrl_q.ie)) |=> !irq)
    else $error("irq raised while disabled");
  a_stop_wake: assert property (
    (stop_mode && (|active) && ctrl_q.ie) |-> ##[1:2] wake_req)
    else $error("no wake in stop on asserted level");
  a_pulldown_sel: assert property (
    ##1 pull_down[3:0] == 4'h0)
    else $error("pulldown on fixed polarity pin");
  a_read_wait: assert property (
    rd_start |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_pull_on_inputs: assert property (
    ##1 (pull_en & $past(shared_port_direction_q) &
         ~$past(key_pin_enable_reg_q)) == '0)
    else $error("pull enabled on driven pin");
  a_dir_drives: assert property (
    ##1 pin_oe == ($past(shared_port_direction_q) &
                   ~$past(key_pin_enable_reg_q)))
    else $error("pin direction not followed");
  a_port_value_out: assert property (
    ##1 pin_out == $past(shared_port_value_q))
    else $error("port value not on pins");
  a_high_pulldown: assert property (
    ##1 pull_down[7:4] == ($past(key_pin_enable_reg_q[7:4]) &
                           $past(ctrl_q.pol)))
    else $error("pulldown not following polarity");
  a_wait_wake: assert property (
    (wait_mode && key_event_flag_d && ctrl_q.ie) |=> wake_req)
    else $error("no wake from wait on event");
  a_irq_raised: assert property (
    (key_event_flag_q && ctrl_q.ie && $past(ctrl_q.ie)) |-> irq)
    else $error("enabled flag without irq");
  a_high_pol_level: assert property (
    (ctrl_q.lvl && key_pin_enable_reg_q[7] && ctrl_q.pol[3] &&
     sync2_q[7]) |=> key_event_flag_q)
    else $error("high level on rising pin missed");
  a_mask_pins: assert property (
    (key_pin_enable_reg_q == '0 && !key_event_flag_q) |=> !key_event_flag_q)
    else $error("flag set with no pin enabled");
  a_edge_only_ack: assert property (
    (!ctrl_q.lvl && !stop_mode && ack_wr && !edge_hit) |=>
    !key_event_flag_q)
    else $error("edge mode ack did not clear");
  a_ack_level_stays: assert property (
    (ctrl_q.lvl && (|active) && ack_wr) |=> key_event_flag_q)
    else $error("ack cleared flag at asserted level");
  a_stop_level_sets: assert property (
    (stop_mode && (|active)) |=> key_event_flag_q)
    else $error("asserted level in stop not seen");

  // ----------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------
  c_edge_event: cover property (edge_hit ##1 irq);
  c_level_ack: cover property (ctrl_q.lvl && ack_wr && set_ev);
  c_stop_wake: cover property (stop_mode ##[1:2] wake_req);
  c_wait_wake: cover property (wait_mode && wake_req);
  c_polled_flag: cover property (key_event_flag_q && !ctrl_q.ie && !irq);
endmodule // kwu_top
`default_nettype wire

/* File: test/kwu_keys.sv */
// kwu_keys: key switches and pull devices on the shared port pins.
// assumes pin controls come straight from the unit on the same clock.
`timescale 1ns/10ps
`default_nettype none
module kwu_keys (
  input  wire logic       hclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pull_en,
  input  wire logic [7:0] pull_down,
  input  wire logic [7:0] press,
  input  wire logic [7:0] act_high,
  output var  logic [7:0] pin_in
);
  // floating pins toggle, so a missing pull never passes by luck
  logic [7:0] last_q = 8'h00;
  always_ff @(posedge hclk) begin
    last_q <= pin_in;
  end
  // released keys rest at the pull level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (press[i]) pin_in[i] = act_high[i];
      else if (pull_en[i]) pin_in[i] = ~pull_down[i];
      else pin_in[i] = ~last_q[i];
    end
  end
endmodule // kwu_keys
`default_nettype wire

/* File: test/testbench.sv */
// testbench: key wake-up unit driven over its bus slave port.
// assumes kwu_keys stands on the pins and hready loops back.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        irq, wake_req, wait_mode, stop_mode;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  pin_in, pin_out, pin_oe, pull_en, pull_down, press;
  logic [7:0]  en, dir, val, pul, e;
  logic [3:0]  pol;
  int          mismatches, comparisons, cyc;
  kwu_top kwu_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pull_en(pull_en),
    .pull_down(pull_down), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .irq(irq), .wake_req(wake_req));
  kwu_keys kwu_keys_inst (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_en(pull_en), .pull_down(pull_down), .press(press),
    .act_high({pol, 4'h0}), .pin_in(pin_in));
  // ----------------------------------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic complete_run;
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // whole run is well under a thousand cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // entered and left at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= kwu_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00);
    chk(rd, {24'h0, x});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // pull only where the pin is an input or a key
  function automatic logic [7:0] exp_pull(input logic [7:0] p,
                                          input logic [7:0] d,
                                          input logic [7:0] k);
    return p & (~d | k);
  endfunction
  // all pins pulled high except the pressed key at its active level
  function automatic logic [7:0] exp_pins(input int k,
                                          input logic [7:0] ah);
    return ~(8'h01 << k) | (ah & (8'h01 << k));
  endfunction
  // key pins enabled, pulled, inputs; stale flag acked
  task automatic cfg(input logic [7:0] c, input logic [7:0] k);
    pol = c[7:4];
    wr(kwu_pkg::OFS_CTRL, c);
    wr(kwu_pkg::OFS_PINEN, k);
    wr(kwu_pkg::OFS_PPULL, 8'hff);
    wr(kwu_pkg::OFS_PDIR, 8'h00);
    tick(4);
    wr(kwu_pkg::OFS_ICLR, 8'h01);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {press, pol, wait_mode, stop_mode} = '0;
    hresetn = 1'b0;
    void'($urandom(49));
    tick(5);
    hresetn <= 1'b1;
    tick(1);
    wr(8'h24, 8'hff);
    wr(kwu_pkg::OFS_ICLR, 8'hff);
    for (int a = 0; a <= 8'h24; a += 4)
      if (a != 8'h14) rdc(a[7:0], 8'h00);
    repeat (16) begin
      {en, dir, val, pul} = $urandom;
      pol = 4'($urandom);
      wr(kwu_pkg::OFS_CTRL, {pol, 4'h0});
      wr(kwu_pkg::OFS_PINEN, en);
      wr(kwu_pkg::OFS_PVAL, val);
      wr(kwu_pkg::OFS_PDIR, dir);
      wr(kwu_pkg::OFS_PPULL, pul);
      tick(2);
      chkp(pin_oe, dir & ~en);
      chkp(pin_out, val);
      chkp(pull_en, exp_pull(pul, dir, en));
      chkp({7'h0, hresp}, 8'h00);
      chkp(pull_down, en & {pol, 4'h0});
      rdc(kwu_pkg::OFS_PINEN, en);
    end
    for (int k = 0; k < 8; k++) begin
      cfg({4'($urandom), 4'h0}, 8'h01 << k);
      e = {pol, 2'h0, k[0], 1'b0};
      wr(kwu_pkg::OFS_IEN, {7'h0, k[0]});
      press <= 8'h01 << ((k + 1) % 8);
      tick(5);
      press <= 8'h00;
      tick(5);
      rdc(kwu_pkg::OFS_ISTAT, 8'h00);
      press <= 8'h01 << k;
      tick(5);
      rdc(kwu_pkg::OFS_ISTAT, 8'h01);
      chkp({7'h0, irq}, {7'h0, k[0]});
      rdc(kwu_pkg::OFS_PIN, exp_pins(k, {pol, 4'h0}));
      press <= 8'h00;
      wr(kwu_pkg::OFS_CTRL, e | 8'h04);
      rdc(kwu_pkg::OFS_CTRL, e);
    end
    cfg(8'h81, 8'h81);
    press <= 8'h81;
    tick(5);
    wr(kwu_pkg::OFS_CTRL, 8'h85);
    rdc(kwu_pkg::OFS_ISTAT, 8'h01);
    press <= 8'h00;
    tick(4);
    wr(kwu_pkg::OFS_CTRL, 8'h85);
    rdc(kwu_pkg::OFS_ISTAT, 8'h00);
    cfg(8'h02, 8'h01);
    wait_mode <= 1'b1;
    press <= 8'h01;
    tick(5);
    chkp({7'h0, wake_req}, 8'h01);
    wait_mode <= 1'b0;
    stop_mode <= 1'b1;
    wr(kwu_pkg::OFS_ICLR, 8'h01);
    rdc(kwu_pkg::OFS_ISTAT, 8'h01);
    chkp({7'h0, wake_req}, 8'h01);
    press <= 8'h00;
    tick(4);
    wr(kwu_pkg::OFS_ICLR, 8'h01);
    rdc(kwu_pkg::OFS_ISTAT, 8'h00);
    chkp({7'h0, wake_req}, 8'h00);
    stop_mode <= 1'b0;
    complete_run();
  end
endmodule // testbench
`default_nettype wire
